// [fmgc_pkg.sv]
// Package with constants, codes and states for the fault monitor and gate control.
package fmgc_pkg;

    // ------------------------------------------------------------------
    // Reaction codes
    // ------------------------------------------------------------------
    localparam logic [1:0] FMGC_OV_HOLD = 2'h3;
    localparam logic [1:0] FMGC_OT_HOLD = 2'h3;
    localparam logic [2:0] FMGC_SH_NONE = 3'h0;
    localparam logic [2:0] FMGC_SH_PH_OFF = 3'h1;
    localparam logic [2:0] FMGC_SH_PH_HOLD = 3'h2;
    localparam logic [2:0] FMGC_SH_ALL_OFF = 3'h3;
    localparam logic [2:0] FMGC_SH_ALL_HOLD = 3'h4;
    localparam logic [2:0] FMGC_SH_CP_OFF = 3'h5;
    localparam logic [2:0] FMGC_SH_CP_HOLD = 3'h6;
    localparam logic [2:0] FMGC_SH_NO_DET = 3'h7;
    localparam logic [1:0] FMGC_FQ_NONE = 2'h0;
    localparam logic [1:0] FMGC_FQ_HOLD = 2'h3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] FMGC_OV_RST = 2'h0;
    localparam logic [1:0] FMGC_OT_RST = 2'h0;
    localparam logic [2:0] FMGC_SH_RST = 3'h2;
    localparam logic [2:0] FMGC_FQ_RST = 3'h0;

    // ------------------------------------------------------------------
    // Filter timing
    // ------------------------------------------------------------------
    localparam int FMGC_FILT_W = 8;
    localparam logic [7:0] FMGC_FILT_RST = 8'h04;
    localparam int FMGC_OV_FILT_CYC = 4;
    localparam int FMGC_OT_FILT_CYC = 4;
    localparam int FMGC_UV_DLY_CYC = 2;
    localparam int FMGC_CNT_W = 8;

    typedef enum logic [1:0] {
        FMGC_ST_DOWN = 2'b00,
        FMGC_ST_BIST = 2'b01,
        FMGC_ST_RUN = 2'b10,
        FMGC_ST_FAIL = 2'b11
    } fmgc_pwr_type;

endpackage : fmgc_pkg

// [fmgc_filter.sv]
// Digital noise filter that accepts a level after a programmable stable time.
`timescale 1ns/1ps
module fmgc_filter
    import fmgc_pkg::*;
#(
    parameter int WIDTH = FMGC_FILT_W,
    parameter logic INIT = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic raw_in,
    input wire logic [WIDTH-1:0] filt_time,
    output logic filt_out
);

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic level;
    } fmgc_filt_type;

    fmgc_filt_type st_ff;
    fmgc_filt_type nxt_st;

    // ------------------------------------------------------------------
    // Filter
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        if (raw_in == st_ff.level) begin
            nxt_st.cnt = '0;
        end else if (st_ff.cnt >= filt_time) begin
            nxt_st.level = raw_in;
            nxt_st.cnt = '0;
        end else begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_ff <= '{cnt: '0, level: INIT};
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    assign filt_out = st_ff.level;

endmodule : fmgc_filter

// [fmgc_core.sv]
// Fault supervision and gate-enable logic for a three-phase pre-driver.
`timescale 1ns/1ps
module fmgc_core
    import fmgc_pkg::*;
#(
    parameter int FILT_W = FMGC_FILT_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic vcc_under_detect_a,
    input wire logic vcc_under_detect_b,
    input wire logic bist_done,
    input wire logic bist_pass,
    input wire logic vcc_over_raw,
    input wire logic [2:0] overtemp_detect_set,
    input wire logic [2:0] high_short_reference,
    input wire logic [2:0] low_short_reference,
    input wire logic [2:0] high_side_cmd,
    input wire logic [2:0] low_side_cmd,
    input wire logic [1:0] short_thresh_sel,
    input wire logic [1:0] short_time_sel,
    input wire logic monitor_tick_1mhz,
    input wire logic freq_low_cmp,
    input wire logic freq_high_cmp,
    input wire logic alarm_in_a,
    input wire logic alarm_in_b,
    input wire logic [FILT_W-1:0] alarm_filt_time,
    input wire logic [1:0] vcc_over_action_sel,
    input wire logic [1:0] overtemp_action_sel,
    input wire logic [2:0] short_action_sel,
    input wire logic [2:0] freq_action_sel,
    input wire logic clr_vcc_over_flag,
    input wire logic clr_overtemp_flag,
    input wire logic clr_short_flags,
    input wire logic clr_freq_flags,
    output logic internal_power_ok,
    output logic fault_flag_n_out,
    output logic vcc_over_detect,
    output logic vcc_over_flag,
    output logic overtemp_flag,
    output logic [5:0] short_flags,
    output logic freq_high_flag,
    output logic freq_low_flag,
    output logic charge_pump_en,
    output logic osc_en,
    output logic [1:0] short_thresh_out,
    output logic [1:0] short_time_out,
    output logic [2:0] gate_en_phase,
    output logic gate_en_relay
);

    typedef struct packed {
        fmgc_pwr_type pwr;
        logic [FMGC_CNT_W-1:0] uv_cnt;
        logic [FMGC_CNT_W-1:0] ov_cnt;
        logic [FMGC_CNT_W-1:0] ot_cnt;
        logic ov_det;
        logic ot_det;
        logic ov_flag;
        logic ot_flag;
        logic [5:0] sh_flag;
        logic [2:0] ph_off;
        logic fh_flag;
        logic fl_flag;
        logic [1:0] ov_mode;
        logic [1:0] ot_mode;
        logic [2:0] sh_mode;
        logic [2:0] fq_mode;
        logic sh_arm;
        logic tick_d;
        logic fq_cnt1;
        logic pwr_ok;
        logic fault_n;
        logic cp_en;
        logic osc;
        logic [1:0] thr;
        logic [1:0] tim;
        logic [2:0] gen;
        logic ren;
    } fmgc_core_type;

    fmgc_core_type st_ff;
    fmgc_core_type nxt_st;
    logic alarm_a_f;
    logic alarm_b_f;
    logic uv_raw;
    logic [5:0] sh_raw;
    logic drv_off;
    logic cp_off;
    logic any_flag;
    logic tick_rise;
    logic tick_fall;

    // ------------------------------------------------------------------
    // Alarm filters
    // ------------------------------------------------------------------
    fmgc_filter #(.WIDTH(FILT_W), .INIT(1'b0)) u_filt_a (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .raw_in(alarm_in_a),
        .filt_time(alarm_filt_time),
        .filt_out(alarm_a_f)
    );

    fmgc_filter #(.WIDTH(FILT_W), .INIT(1'b0)) u_filt_b (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .raw_in(alarm_in_b),
        .filt_time(alarm_filt_time),
        .filt_out(alarm_b_f)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        uv_raw = vcc_under_detect_a | vcc_under_detect_b;
        tick_rise = monitor_tick_1mhz & ~st_ff.tick_d;
        tick_fall = ~monitor_tick_1mhz & st_ff.tick_d;
        nxt_st.tick_d = monitor_tick_1mhz;
        nxt_st.thr = short_thresh_sel;
        nxt_st.tim = short_time_sel;
        // Undervoltage delay and power sequencing.
        if (uv_raw) begin
            if (st_ff.uv_cnt >= FMGC_CNT_W'(FMGC_UV_DLY_CYC)) begin
                nxt_st.pwr = FMGC_ST_DOWN;
            end else begin
                nxt_st.uv_cnt = st_ff.uv_cnt + 1'b1;
            end
        end else begin
            nxt_st.uv_cnt = '0;
        end
        unique case (st_ff.pwr)
            FMGC_ST_DOWN: begin
                if (!uv_raw) begin
                    nxt_st.pwr = FMGC_ST_BIST;
                end
            end
            FMGC_ST_BIST: begin
                if (bist_done && st_ff.pwr == nxt_st.pwr) begin
                    nxt_st.pwr = bist_pass ? FMGC_ST_RUN : FMGC_ST_FAIL;
                end
            end
            FMGC_ST_RUN: begin
            end
            FMGC_ST_FAIL: begin
            end
        endcase
        // Overvoltage filter and flag.
        if (vcc_over_raw) begin
            if (st_ff.ov_cnt >= FMGC_CNT_W'(FMGC_OV_FILT_CYC)) begin
                nxt_st.ov_det = 1'b1;
            end else begin
                nxt_st.ov_cnt = st_ff.ov_cnt + 1'b1;
            end
        end else begin
            nxt_st.ov_cnt = '0;
            nxt_st.ov_det = 1'b0;
        end
        if (clr_vcc_over_flag && !st_ff.ov_det) begin
            nxt_st.ov_flag = 1'b0;
        end
        if (nxt_st.ov_det) begin
            nxt_st.ov_flag = 1'b1;
        end
        if (!st_ff.ov_flag && !st_ff.ov_det) begin
            nxt_st.ov_mode = vcc_over_action_sel;
        end
        // Overtemperature filter and flag.
        if (|overtemp_detect_set) begin
            if (st_ff.ot_cnt >= FMGC_CNT_W'(FMGC_OT_FILT_CYC)) begin
                nxt_st.ot_det = 1'b1;
            end else begin
                nxt_st.ot_cnt = st_ff.ot_cnt + 1'b1;
            end
        end else begin
            nxt_st.ot_cnt = '0;
            nxt_st.ot_det = 1'b0;
        end
        if (clr_overtemp_flag && !st_ff.ot_det) begin
            nxt_st.ot_flag = 1'b0;
        end
        if (nxt_st.ot_det) begin
            nxt_st.ot_flag = 1'b1;
        end
        if (!st_ff.ot_flag && !st_ff.ot_det) begin
            nxt_st.ot_mode = overtemp_action_sel;
        end
        // Short detection, armed by an alarm low and idle while drivers are off.
        if (!alarm_a_f || !alarm_b_f) begin
            nxt_st.sh_arm = 1'b1;
        end
        sh_raw[2:0] = low_short_reference & low_side_cmd;
        sh_raw[5:3] = high_short_reference & high_side_cmd;
        if (clr_short_flags) begin
            nxt_st.sh_flag = '0;
            nxt_st.ph_off = '0;
        end
        if (st_ff.sh_arm && st_ff.pwr == FMGC_ST_RUN && st_ff.sh_mode != FMGC_SH_NO_DET
                && |st_ff.gen) begin
            nxt_st.sh_flag = nxt_st.sh_flag | sh_raw;
        end
        if (!(|st_ff.sh_flag)) begin
            nxt_st.sh_mode = short_action_sel;
        end
        // Phase-only reactions: hold keeps the phase off until the flag clears.
        for (int i = 0; i < 3; i++) begin
            if ((st_ff.sh_mode == FMGC_SH_PH_OFF || st_ff.sh_mode == FMGC_SH_PH_HOLD)
                    && (sh_raw[i] || sh_raw[i+3]) && nxt_st.sh_flag[i] | nxt_st.sh_flag[i+3]) begin
                nxt_st.ph_off[i] = 1'b1;
            end else if (st_ff.sh_mode == FMGC_SH_PH_OFF) begin
                nxt_st.ph_off[i] = 1'b0;
            end
        end
        // Frequency monitors.
        if (st_ff.fq_mode[2]) begin
            nxt_st.fq_cnt1 = 1'b0;
        end else begin
            if (tick_rise && freq_low_cmp) begin
                nxt_st.fl_flag = 1'b1;
            end
            if (tick_rise) begin
                nxt_st.fq_cnt1 = 1'b1;
            end else if (tick_fall) begin
                nxt_st.fq_cnt1 = 1'b0;
                if (st_ff.fq_cnt1 && freq_high_cmp) begin
                    nxt_st.fh_flag = 1'b1;
                end
            end
        end
        if (clr_freq_flags && !freq_low_cmp && !freq_high_cmp) begin
            nxt_st.fl_flag = nxt_st.fl_flag & tick_rise & freq_low_cmp;
            nxt_st.fh_flag = 1'b0;
        end
        if (!st_ff.fl_flag && !st_ff.fh_flag) begin
            nxt_st.fq_mode = freq_action_sel;
        end
        // Off requests from each reaction mode.
        drv_off = 1'b0;
        cp_off = 1'b0;
        if (st_ff.ov_det || (st_ff.ov_flag && st_ff.ov_mode == FMGC_OV_HOLD)) begin
            drv_off = st_ff.ov_mode != 2'h0;
            cp_off = st_ff.ov_mode[1];
        end
        if (st_ff.ot_det || (st_ff.ot_flag && st_ff.ot_mode == FMGC_OT_HOLD)) begin
            drv_off = drv_off | (st_ff.ot_mode != 2'h0);
            cp_off = cp_off | st_ff.ot_mode[1];
        end
        if (|st_ff.sh_flag) begin
            if ((st_ff.sh_mode == FMGC_SH_ALL_OFF || st_ff.sh_mode == FMGC_SH_CP_OFF)
                    && |sh_raw) begin
                drv_off = 1'b1;
                cp_off = cp_off | (st_ff.sh_mode == FMGC_SH_CP_OFF);
            end
            if (st_ff.sh_mode == FMGC_SH_ALL_HOLD || st_ff.sh_mode == FMGC_SH_CP_HOLD) begin
                drv_off = 1'b1;
                cp_off = cp_off | (st_ff.sh_mode == FMGC_SH_CP_HOLD);
            end
        end
        if (!st_ff.fq_mode[2] && st_ff.fq_mode != FMGC_FQ_NONE && (st_ff.fl_flag || st_ff.fh_flag)
                && (freq_low_cmp || freq_high_cmp || st_ff.fq_mode[1:0] == FMGC_FQ_HOLD)) begin
            drv_off = 1'b1;
            cp_off = cp_off | st_ff.fq_mode[1];
        end
        any_flag = st_ff.ov_flag | st_ff.ot_flag | (|st_ff.sh_flag) | st_ff.fl_flag
            | st_ff.fh_flag;
        // Outputs.
        nxt_st.pwr_ok = (nxt_st.pwr != FMGC_ST_DOWN);
        nxt_st.osc = nxt_st.pwr_ok;
        nxt_st.cp_en = (st_ff.pwr == FMGC_ST_RUN) && !cp_off;
        nxt_st.fault_n = (st_ff.pwr == FMGC_ST_RUN) && !any_flag && !st_ff.ov_det;
        for (int i = 0; i < 3; i++) begin
            nxt_st.gen[i] = st_ff.pwr_ok && st_ff.pwr == FMGC_ST_RUN && alarm_a_f && alarm_b_f
                && !drv_off && !st_ff.ph_off[i];
        end
        nxt_st.ren = st_ff.pwr_ok && st_ff.pwr == FMGC_ST_RUN && alarm_a_f && alarm_b_f
            && !drv_off;
        if (st_ff.pwr != FMGC_ST_RUN) begin
            nxt_st.sh_arm = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_ff <= '{pwr: FMGC_ST_DOWN, uv_cnt: '0, ov_cnt: '0, ot_cnt: '0, ov_det: 1'b0,
                ot_det: 1'b0, ov_flag: 1'b0, ot_flag: 1'b0, sh_flag: '0, ph_off: '0,
                fh_flag: 1'b0, fl_flag: 1'b0, ov_mode: FMGC_OV_RST, ot_mode: FMGC_OT_RST,
                sh_mode: FMGC_SH_RST, fq_mode: FMGC_FQ_RST, sh_arm: 1'b0, tick_d: 1'b0,
                fq_cnt1: 1'b0, pwr_ok: 1'b0, fault_n: 1'b0, cp_en: 1'b0, osc: 1'b0,
                thr: '0, tim: '0, gen: '0, ren: 1'b0};
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    assign internal_power_ok = st_ff.pwr_ok;
    assign fault_flag_n_out = st_ff.fault_n;
    assign vcc_over_detect = st_ff.ov_det;
    assign vcc_over_flag = st_ff.ov_flag;
    assign overtemp_flag = st_ff.ot_flag;
    assign short_flags = st_ff.sh_flag;
    assign freq_high_flag = st_ff.fh_flag;
    assign freq_low_flag = st_ff.fl_flag;
    assign charge_pump_en = st_ff.cp_en;
    assign osc_en = st_ff.osc;
    assign short_thresh_out = st_ff.thr;
    assign short_time_out = st_ff.tim;
    assign gate_en_phase = st_ff.gen;
    assign gate_en_relay = st_ff.ren;

endmodule : fmgc_core

// [fmgc_core_properties.sv]
// Concurrent checks on the ports of the fault monitor and gate control.
`timescale 1ns/1ps
module fmgc_core_properties
    import fmgc_pkg::*;
#(
    parameter int FILT_W = FMGC_FILT_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic vcc_under_detect_a,
    input wire logic vcc_under_detect_b,
    input wire logic vcc_over_raw,
    input wire logic [2:0] overtemp_detect_set,
    input wire logic [1:0] short_thresh_sel,
    input wire logic [1:0] short_time_sel,
    input wire logic alarm_in_a,
    input wire logic alarm_in_b,
    input wire logic [FILT_W-1:0] alarm_filt_time,
    input wire logic clr_vcc_over_flag,
    input wire logic clr_overtemp_flag,
    input wire logic internal_power_ok,
    input wire logic fault_flag_n_out,
    input wire logic vcc_over_detect,
    input wire logic vcc_over_flag,
    input wire logic overtemp_flag,
    input wire logic [5:0] short_flags,
    input wire logic charge_pump_en,
    input wire logic osc_en,
    input wire logic [1:0] short_thresh_out,
    input wire logic [1:0] short_time_out,
    input wire logic [2:0] gate_en_phase,
    input wire logic gate_en_relay
);
    // ------------------------------------------------------------------
    // Alarm low counter and checks
    // ------------------------------------------------------------------
    logic [FILT_W:0] low_cnt_ff;
    wire logic any_flag = vcc_over_flag || overtemp_flag || (|short_flags);
    wire logic gates_off = (gate_en_phase == 3'h0) && !gate_en_relay;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_cnt_ff <= '0;
        end else if (alarm_in_a && alarm_in_b) begin
            low_cnt_ff <= '0;
        end else if (!(&low_cnt_ff)) begin
            low_cnt_ff <= low_cnt_ff + 1'b1;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence s_ov_high;
        vcc_over_raw [*5];
    endsequence
    sequence s_hot_held;
        (|overtemp_detect_set) [*6];
    endsequence
    sequence s_uv_held;
        (vcc_under_detect_a || vcc_under_detect_b) [*3];
    endsequence
    a_gate_pwr_off: assert property (!internal_power_ok [*2] |-> gates_off)
        else $error("gates on, no power ok");
    a_gate_alarm_off: assert property (low_cnt_ff > alarm_filt_time + 3 |-> gates_off)
        else $error("gates on, alarm low");
    a_uv_shutdown: assert property (s_uv_held |-> ##[0:2] (!internal_power_ok
        && !fault_flag_n_out && !osc_en && !charge_pump_en && gates_off))
        else $error("no undervoltage shutdown");
    a_ov_detect: assert property (s_ov_high |-> ##[1:2] (vcc_over_detect && !fault_flag_n_out))
        else $error("overvoltage missed");
    a_ov_clr_refused: assert property (vcc_over_detect && vcc_over_flag && clr_vcc_over_flag
        |=> vcc_over_flag)
        else $error("overvoltage clear taken");
    a_ot_clr_refused: assert property (s_hot_held ##0 (overtemp_flag && clr_overtemp_flag)
        |=> overtemp_flag)
        else $error("overtemperature clear taken");
    a_ov_clr_works: assert property (!vcc_over_raw && !vcc_over_detect && clr_vcc_over_flag
        |=> !vcc_over_flag)
        else $error("overvoltage clear lost");
    a_flag_fault_low: assert property (any_flag && $past(any_flag) |-> !fault_flag_n_out)
        else $error("fault high with flag");
    a_sel_pass: assert property (1'b1 |=> short_thresh_out == $past(short_thresh_sel)
        && short_time_out == $past(short_time_sel))
        else $error("short selects lost");
endmodule : fmgc_core_properties

bind fmgc_core fmgc_core_properties #(.FILT_W(FILT_W)) u_fmgc_props (
    .ref_clk, .rst, .vcc_under_detect_a, .vcc_under_detect_b, .vcc_over_raw,
    .overtemp_detect_set, .short_thresh_sel, .short_time_sel, .alarm_in_a, .alarm_in_b,
    .alarm_filt_time, .clr_vcc_over_flag, .clr_overtemp_flag, .internal_power_ok,
    .fault_flag_n_out, .vcc_over_detect, .vcc_over_flag, .overtemp_flag, .short_flags,
    .charge_pump_en, .osc_en, .short_thresh_out, .short_time_out, .gate_en_phase, .gate_en_relay
);

// [fmgc_host_model.sv]
// Host model driving alarms and phase commands after a lag.
`timescale 1ns/1ps
module fmgc_host_model (
    input wire logic ref_clk,
    input wire logic [3:0] lag,
    input wire logic [1:0] want_alarm,
    input wire logic [2:0] want_hi,
    input wire logic [2:0] want_lo,
    output logic alarm_in_a,
    output logic alarm_in_b,
    output logic [2:0] high_side_cmd,
    output logic [2:0] low_side_cmd
);
    logic [3:0] wait_cnt = 4'h0;
    initial begin
        {alarm_in_b, alarm_in_a, high_side_cmd, low_side_cmd} = 8'h00;
    end
    always @(negedge ref_clk) begin
        if ({want_alarm, want_hi, want_lo} == {alarm_in_b, alarm_in_a, high_side_cmd, low_side_cmd}) begin
            wait_cnt <= 4'h0;
        end else if (wait_cnt >= lag) begin
            {alarm_in_b, alarm_in_a} <= want_alarm;
            high_side_cmd <= want_hi;
            low_side_cmd <= want_lo;
            wait_cnt <= 4'h0;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule : fmgc_host_model

// [fmgc_core_tb_top.sv]
// Self-checking bench for the fault monitor and gate control.
`timescale 1ns/1ps
module fmgc_core_tb_top
    import fmgc_pkg::*;
;
    logic ref_clk = 1'b0, rst = 1'b1, bist_done = 1'b0, bist_pass = 1'b0, monitor_tick_1mhz = 1'b0;
    logic [1:0] vuv = 2'h0, src_on = 2'h0, fcmp = 2'h0, want_alarm = 2'h0;
    logic [1:0] act_sel [2] = '{2'h0, 2'h0};
    logic [1:0] short_thresh_sel = 2'h0, short_time_sel = 2'h0;
    logic [2:0] hot = 3'h1, high_short_reference = 3'h0, low_short_reference = 3'h0;
    logic [2:0] short_action_sel = FMGC_SH_RST, freq_action_sel = 3'h0, want_hi = 3'h0, want_lo = 3'h0;
    logic [3:0] clr = 4'h0, lag = 4'h0;
    logic [7:0] alarm_filt_time = 8'h04;
    logic [5:0] sc, short_flags;
    logic alarm_in_a, alarm_in_b, internal_power_ok, fault_flag_n_out, vcc_over_flag, overtemp_flag;
    logic freq_high_flag, freq_low_flag, charge_pump_en, osc_en, gate_en_relay, vcc_over_detect;
    logic [2:0] high_side_cmd, low_side_cmd, gate_en_phase;
    logic [1:0] short_thresh_out, short_time_out;
    int n_fail = 0, checked = 0, cyc = 0, i = 0, p = 0;
    integer seed = 32'hfe2b;
    wire logic [2:0] overtemp_detect_set = src_on[1] ? hot : 3'h0;
    wire logic [1:0] flg = {overtemp_flag, vcc_over_flag};
    wire logic [3:0] gates = {gate_en_relay, gate_en_phase};
    fmgc_host_model host (.ref_clk, .lag, .want_alarm, .want_hi, .want_lo, .alarm_in_a,
        .alarm_in_b, .high_side_cmd, .low_side_cmd);
    fmgc_core dut (.ref_clk, .rst, .clk_en(1'b1), .vcc_under_detect_a(vuv[0]),
        .vcc_under_detect_b(vuv[1]), .bist_done, .bist_pass, .vcc_over_raw(src_on[0]),
        .overtemp_detect_set, .high_short_reference, .low_short_reference, .high_side_cmd,
        .low_side_cmd, .short_thresh_sel, .short_time_sel, .monitor_tick_1mhz,
        .freq_low_cmp(fcmp[0]), .freq_high_cmp(fcmp[1]), .alarm_in_a, .alarm_in_b,
        .alarm_filt_time, .vcc_over_action_sel(act_sel[0]), .overtemp_action_sel(act_sel[1]),
        .short_action_sel, .freq_action_sel, .clr_vcc_over_flag(clr[0]),
        .clr_overtemp_flag(clr[1]), .clr_short_flags(clr[2]), .clr_freq_flags(clr[3]),
        .internal_power_ok, .fault_flag_n_out, .vcc_over_detect, .vcc_over_flag, .overtemp_flag,
        .short_flags, .freq_high_flag, .freq_low_flag, .charge_pump_en, .osc_en,
        .short_thresh_out, .short_time_out, .gate_en_phase, .gate_en_relay);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail = n_fail + 1;
            test_done();
        end
    end
    function automatic logic [3:0] exp_gates(input logic on, input logic [2:0] off);
        return on ? {1'b1, ~off} : 4'h0;
    endfunction : exp_gates
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic cyc_wait(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc_wait
    task automatic pulse_clr(input int b);
        clr[b] <= 1'b1;
        cyc_wait(1);
        clr[b] <= 1'b0;
    endtask : pulse_clr
    task automatic ticks(input int n);
        repeat (n) begin
            monitor_tick_1mhz <= 1'b1;
            cyc_wait(10);
            monitor_tick_1mhz <= 1'b0;
            cyc_wait(10);
        end
    endtask : ticks
    task automatic run_fault(input int s, input logic [1:0] m);
        hot <= 3'h1 << ($unsigned($random(seed)) % 3);
        act_sel[s] <= m;
        cyc_wait(2);
        src_on[s] <= 1'b1;
        cyc_wait(9);
        chk("fault_n", fault_flag_n_out, 0);
        chk("gates", gates, exp_gates(m == 2'h0, 3'h0));
        chk("pump", charge_pump_en, m < 2'h2);
        act_sel[s] <= ~m;
        pulse_clr(s);
        cyc_wait(2);
        chk("flag", flg[s], 1);
        src_on[s] <= 1'b0;
        cyc_wait(8);
        chk("gates", gates, exp_gates(m != FMGC_OV_HOLD, 3'h0));
        chk("fault_n", fault_flag_n_out, 0);
        pulse_clr(s);
        cyc_wait(3);
        chk("flag_fault", {flg[s], fault_flag_n_out}, 2'b01);
        chk("gates", gates, exp_gates(1'b1, 3'h0));
    endtask : run_fault
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        alarm_filt_time = 8'(2 + $unsigned($random(seed)) % 6);
        lag = 4'($unsigned($random(seed)) % 3);
        cyc_wait(20);
        rst <= 1'b0;
        cyc_wait(2);
        {bist_done, bist_pass} <= 2'b11;
        while (internal_power_ok !== 1'b1 && i < 50) begin
            cyc_wait(1);
            i++;
        end
        cyc_wait(alarm_filt_time + lag + 6);
        chk("pok_fault_pump", {internal_power_ok, fault_flag_n_out, charge_pump_en}, 3'h7);
        chk("gates", gates, 4'h0);
        for (int k = 0; k < 8; k++) begin
            want_alarm <= (k < 6) ? 2'($unsigned($random(seed)) % 3) : 2'h3;
            cyc_wait(alarm_filt_time + lag + 6);
            chk("gates", gates, exp_gates(want_alarm == 2'h3, 3'h0));
        end
        repeat (4) begin
            want_alarm <= 2'h3 ^ (2'h1 << ($unsigned($random(seed)) % 2));
            cyc_wait(alarm_filt_time - 1);
            want_alarm <= 2'h3;
            repeat (alarm_filt_time + lag + 6) begin
                cyc_wait(1);
                chk("gates", gates, exp_gates(1'b1, 3'h0));
            end
        end
        for (int m = 0; m < 8; m++) run_fault(m % 2, 2'(m / 2));
        for (int k = 0; k < 8; k++) begin
            p = $unsigned($random(seed)) % 3;
            sc = 6'h1 << (p + 3 * (k % 2));
            short_action_sel <= 3'(k);
            {short_thresh_sel, short_time_sel} <= 4'($random(seed));
            cyc_wait(2);
            {want_hi, want_lo} <= sc;
            {high_short_reference, low_short_reference} <= sc;
            i = 0;
            while (short_flags === 6'h0 && i < ((k == 7) ? 200 : 2000)) begin
                cyc_wait(1);
                i++;
            end
            cyc_wait(3);
            chk("short", short_flags, (k == 7) ? 6'h0 : sc);
            chk("gates", gates, exp_gates(k < 3 || k == 7,
                {3{k == 1 || k == 2}} & (sc[2:0] | sc[5:3])));
            {want_hi, want_lo, high_short_reference, low_short_reference} <= 12'h0;
            cyc_wait(lag + 8);
            chk("fault_n", fault_flag_n_out, k == 7);
            chk("gates", gates, exp_gates(k != 4 && k != 6,
                {3{k == 2}} & (sc[2:0] | sc[5:3])));
            pulse_clr(2);
            cyc_wait(3);
            chk("short_fault", {short_flags, fault_flag_n_out}, 7'h01);
            chk("gates", gates, exp_gates(1'b1, 3'h0));
        end
        for (int c = 0; c < 2; c++) begin
            freq_action_sel <= 3'h4;
            cyc_wait(2);
            fcmp <= 2'h1 << c;
            ticks(3);
            chk("freq", {freq_high_flag, freq_low_flag}, 2'h0);
            fcmp <= 2'h0;
            cyc_wait(2);
            freq_action_sel <= FMGC_FQ_RST;
            cyc_wait(2);
            fcmp <= 2'h1 << c;
            ticks(3);
            chk("freq", {freq_high_flag, freq_low_flag}, 2'h1 << c);
            chk("fault_n", fault_flag_n_out, 0);
            fcmp <= 2'h0;
            ticks(1);
            chk("gates", gates, exp_gates(1'b1, 3'h0));
            pulse_clr(3);
            cyc_wait(3);
            chk("freq_fault", {freq_high_flag, freq_low_flag, fault_flag_n_out}, 3'h1);
        end
        for (int u = 0; u < 2; u++) begin
            bist_pass <= (u == 0);
            vuv <= 2'h1 << u;
            cyc_wait(6);
            chk("pok_fault", {internal_power_ok, fault_flag_n_out}, 2'h0);
            chk("osc_pump", {osc_en, charge_pump_en}, 2'h0);
            chk("gates", gates, 4'h0);
            vuv <= 2'h0;
            cyc_wait(40);
            chk("fault_pump", {fault_flag_n_out, charge_pump_en}, (u == 0) ? 2'h3 : 2'h0);
            chk("gates", gates, exp_gates(u == 0, 3'h0));
        end
        test_done();
    end
endmodule : fmgc_core_tb_top
